// ==== scr_device.sv ====
// device end: serial configuration registers and align-reference clock control
`timescale 1ns/10ps
`include "scr_defs.svh"

// Functional notes
// - soft-reset bit resets everything, then self-clears
// - soft reset completes within 750 ns
// - ascend bit picks increment or decrement streaming
// - separate-output bit reads one; reads on sdo
// - mode field: 0 normal, 3 full power down
// - 16-bit maker code, read-only, fixed
// - address-hold bit freezes streaming address
// - bit 5 enables align-reference receiver
// - bit 6 enables align-reference processor
// - host enables receiver no later than processor; scr_host fixes later frame bytes as if ascending, even in descend or hold
// - fine-step bit shrinks windowing delay steps
// - four-bit field selects capture delay
// - host writes reserved fields with reset value; scr_host fixes later frame bytes as if ascending, even in descend or hold
// - 24-bit read-only edge position status
module scr_device #(
    parameter logic [15:0] MAKER_CODE = 16'h5A3C // arbitrary value
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // serial link
    scr_spi_if.dev spi,
    // chip control
    output logic chip_reset_o,
    output scr_pkg::scr_mode_t op_mode_o,
    output logic power_down_o,
    // alignment reference
    output logic align_ref_receiver_enable_o,
    output logic align_ref_processor_enable_o,
    output logic align_ref_fine_step_o,
    output logic [3:0] align_ref_delay_select_o,
    input wire logic [23:0] align_ref_edge_position_i
);
    import scr_pkg::*;

    // register storage
    logic [7:0] interface_config;
    logic [7:0] device_power_config;
    logic [7:0] user_serial_config;
    logic [7:0] align_ref_clock_control;

    // soft reset
    logic [3:0] srst_cnt;
    logic busy;
    logic srst_req;

    // serial engine
    logic sclk_q;
    logic sclk_rise;
    logic sclk_fall;
    logic [4:0] bit_cnt;
    logic [14:0] hdr_sh;
    logic [6:0] wr_sh;
    logic rd_mode;
    logic [14:0] addr;
    logic [14:0] next_addr;
    logic [14:0] ld_addr;
    logic [7:0] ld_data;
    logic [7:0] tx_sh;
    logic sdo_q;
    logic hdr_done;
    logic byte_done;
    logic wr_strobe;
    logic [7:0] wr_byte;

    assign busy = (srst_cnt != 4'h0);

    // edge detect on the serial clock; pins are synchronous to ref_clk_i
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= spi.sclk;
        end
    end

    // edges are ignored while the soft reset runs
    assign sclk_rise = spi.sclk & ~sclk_q & ~spi.cs_n & ~busy;
    assign sclk_fall = ~spi.sclk & sclk_q & ~spi.cs_n & ~busy;
    assign hdr_done = sclk_rise && (bit_cnt == `SCR_HDR_LAST);
    assign byte_done = sclk_rise && (bit_cnt == `SCR_DATA_LAST);
    assign wr_strobe = byte_done & ~rd_mode;
    assign wr_byte = {wr_sh, spi.sdi};
    assign srst_req = wr_strobe && (addr == `SCR_OFS_IFACE) && wr_byte[`SCR_BIT_SOFT_RESET];

    // streaming address step
    always_comb begin
        if (user_serial_config[`SCR_BIT_ADDR_HOLD]) begin
            next_addr = addr;
        end else if (interface_config[`SCR_BIT_ASCEND]) begin
            next_addr = 15'(addr + 15'h0001);
        end else begin
            next_addr = 15'(addr - 15'h0001);
        end
    end

    // address whose data is loaded for the next byte out
    assign ld_addr = hdr_done ? {hdr_sh[13:0], spi.sdi} : next_addr;

    // read decode
    always_comb begin
        ld_data = 8'h00;
        if (ld_addr == `SCR_OFS_IFACE) begin
            ld_data = interface_config;
        end else if (ld_addr == `SCR_OFS_DEVPWR) begin
            ld_data = device_power_config;
        end else if (ld_addr == `SCR_OFS_MAKER_LO) begin
            ld_data = MAKER_CODE[7:0];
        end else if (ld_addr == `SCR_OFS_MAKER_HI) begin
            ld_data = MAKER_CODE[15:8];
        end else if (ld_addr == `SCR_OFS_USER) begin
            ld_data = user_serial_config;
        end else if (ld_addr == `SCR_OFS_CLKCTL) begin
            ld_data = align_ref_clock_control;
        end else if (ld_addr == `SCR_OFS_EDGE_B0) begin
            ld_data = align_ref_edge_position_i[7:0];
        end else if (ld_addr == `SCR_OFS_EDGE_B1) begin
            ld_data = align_ref_edge_position_i[15:8];
        end else if (ld_addr == `SCR_OFS_EDGE_B2) begin
            ld_data = align_ref_edge_position_i[23:16];
        end
    end

    // soft reset timer: registers are held at reset for the whole count
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            srst_cnt <= 4'h0;
        end else if (srst_req) begin
            srst_cnt <= 4'(`SCR_SRST_DEV_CYC);
        end else if (busy) begin
            srst_cnt <= 4'(srst_cnt - 4'h1);
        end
    end

    // chip-wide reset output follows the timer
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            chip_reset_o <= 1'b0;
        end else begin
            chip_reset_o <= srst_req | (srst_cnt > 4'h1);
        end
    end

    // bit counter and header capture
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bit_cnt <= 5'h00;
            hdr_sh <= 15'h0000;
            wr_sh <= 7'h00;
        end else if (spi.cs_n || busy) begin
            bit_cnt <= 5'h00;
            hdr_sh <= 15'h0000;
            wr_sh <= 7'h00;
        end else if (sclk_rise) begin
            if (bit_cnt < `SCR_DATA_FIRST) begin
                hdr_sh <= {hdr_sh[13:0], spi.sdi};
            end else begin
                wr_sh <= {wr_sh[5:0], spi.sdi};
            end
            if (byte_done) begin
                bit_cnt <= `SCR_DATA_FIRST;
            end else begin
                bit_cnt <= 5'(bit_cnt + 5'h01);
            end
        end
    end

    // transfer direction and register address
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_mode <= 1'b0;
            addr <= 15'h0000;
        end else if (spi.cs_n || busy) begin
            rd_mode <= 1'b0;
        end else if (hdr_done) begin
            rd_mode <= hdr_sh[14];
            addr <= ld_addr;
        end else if (byte_done) begin
            addr <= next_addr;
        end
    end

    // read data leaves only on the dedicated output, changed on falling edges
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_sh <= 8'h00;
            sdo_q <= 1'b0;
        end else if (spi.cs_n || busy) begin
            tx_sh <= 8'h00;
            sdo_q <= 1'b0;
        end else if (hdr_done || byte_done) begin
            tx_sh <= ld_data;
        end else if (sclk_fall && (bit_cnt >= `SCR_DATA_FIRST)) begin
            sdo_q <= rd_mode & tx_sh[7];
            tx_sh <= {tx_sh[6:0], 1'b0};
        end
    end

    assign spi.sdo = sdo_q;

    // interface_config: soft-reset bit never stored, separate-output bit pinned
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            interface_config <= `SCR_RST_IFACE;
        end else if (busy || srst_req) begin
            interface_config <= `SCR_RST_IFACE;
        end else if (wr_strobe && (addr == `SCR_OFS_IFACE)) begin
            interface_config <= (wr_byte & 8'h6F) | (8'h01 << `SCR_BIT_SEP_OUT);
        end
    end

    // device_power_config
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            device_power_config <= `SCR_RST_DEVPWR;
        end else if (busy) begin
            device_power_config <= `SCR_RST_DEVPWR;
        end else if (wr_strobe && (addr == `SCR_OFS_DEVPWR)) begin
            device_power_config <= wr_byte;
        end
    end

    // user_serial_config
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            user_serial_config <= `SCR_RST_USER;
        end else if (busy) begin
            user_serial_config <= `SCR_RST_USER;
        end else if (wr_strobe && (addr == `SCR_OFS_USER)) begin
            user_serial_config <= wr_byte;
        end
    end

    // align_ref_clock_control
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            align_ref_clock_control <= `SCR_RST_CLKCTL;
        end else if (busy) begin
            align_ref_clock_control <= `SCR_RST_CLKCTL;
        end else if (wr_strobe && (addr == `SCR_OFS_CLKCTL)) begin
            align_ref_clock_control <= wr_byte;
        end
    end

    // reserved codes 1 and 2 run as normal; only code 3 powers down
    assign op_mode_o = scr_mode_t'(device_power_config[1:0]);
    assign power_down_o = (op_mode_o == SCR_MODE_POWER_DOWN);

    assign align_ref_receiver_enable_o = align_ref_clock_control[`SCR_BIT_RECV_EN];
    // processor only acts once the receiver is on, so a wrong order stays harmless
    assign align_ref_processor_enable_o = align_ref_clock_control[`SCR_BIT_PROC_EN]
        & align_ref_clock_control[`SCR_BIT_RECV_EN];
    assign align_ref_fine_step_o = align_ref_clock_control[`SCR_BIT_FINE_STEP];
    assign align_ref_delay_select_o = align_ref_clock_control[3:0];

endmodule : scr_device

// ==== scr_defs.svh ====
// register offsets, field positions, reset values and timing counts for the serial config block
`ifndef SCR_DEFS_SVH
`define SCR_DEFS_SVH

// register offsets (15-bit serial address space)
`define SCR_OFS_IFACE 15'h0000
`define SCR_OFS_DEVPWR 15'h0002
`define SCR_OFS_MAKER_LO 15'h000C
`define SCR_OFS_MAKER_HI 15'h000D
`define SCR_OFS_USER 15'h0010
`define SCR_OFS_CLKCTL 15'h0029
`define SCR_OFS_EDGE_B0 15'h002C
`define SCR_OFS_EDGE_B1 15'h002D
`define SCR_OFS_EDGE_B2 15'h002E

// reset values
`define SCR_RST_IFACE 8'h30
`define SCR_RST_DEVPWR 8'h00
`define SCR_RST_USER 8'h00
`define SCR_RST_CLKCTL 8'h80

// field positions
`define SCR_BIT_SOFT_RESET 7
`define SCR_BIT_ASCEND 5
`define SCR_BIT_SEP_OUT 4
`define SCR_BIT_ADDR_HOLD 0
`define SCR_BIT_CLK_RSV 7
`define SCR_BIT_PROC_EN 6
`define SCR_BIT_RECV_EN 5
`define SCR_BIT_FINE_STEP 4

// writable bits that are not reserved
`define SCR_WMASK_IFACE 8'hA0
`define SCR_WMASK_DEVPWR 8'h03
`define SCR_WMASK_USER 8'h01

// frame layout: one read flag, 15 address bits, then data bytes
`define SCR_HDR_LAST 5'h0F
`define SCR_DATA_FIRST 5'h10
`define SCR_DATA_LAST 5'h17

// timing
`define SCR_CLK_PERIOD_NS 100
`define SCR_SRST_NS 750
`define SCR_SRST_DEV_CYC (`SCR_SRST_NS / `SCR_CLK_PERIOD_NS)
`define SCR_SRST_HOST_CYC ((`SCR_SRST_NS + `SCR_CLK_PERIOD_NS - 1) / `SCR_CLK_PERIOD_NS)

`endif

// ==== scr_pkg.sv ====
// shared types for the serial config block
package scr_pkg;

    typedef enum logic [1:0] {
        SCR_MODE_NORMAL = 2'b00,
        SCR_MODE_RSV1 = 2'b01,
        SCR_MODE_RSV2 = 2'b10,
        SCR_MODE_POWER_DOWN = 2'b11
    } scr_mode_t;

    typedef enum logic [1:0] {
        SCR_HOST_IDLE = 2'b00,
        SCR_HOST_SHIFT = 2'b01,
        SCR_HOST_TRAIL = 2'b10,
        SCR_HOST_GAP = 2'b11
    } scr_host_state_t;

endpackage : scr_pkg

// ==== scr_spi_if.sv ====
// serial link between the config host and the device register bank
`timescale 1ns/10ps
interface scr_spi_if;
    logic sclk;
    logic cs_n;
    logic sdi;
    logic sdo;

    modport dev (input sclk, input cs_n, input sdi, output sdo);
    modport host (output sclk, output cs_n, output sdi, input sdo);
endinterface : scr_spi_if

// ==== scr_host.sv ====
// host end: drives serial frames into the device register bank
`timescale 1ns/10ps
`include "scr_defs.svh"

module scr_host #(
    parameter int SCLK_HALF = 2
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // serial link
    scr_spi_if.host spi,
    // user request
    input wire logic start_i,
    input wire logic read_i,
    input wire logic [14:0] addr_i,
    input wire logic [1:0] nbytes_i,
    input wire logic [23:0] wdata_i,
    // user answer
    output logic busy_o,
    output logic done_o,
    output logic [23:0] rdata_o
);
    import scr_pkg::*;

    scr_host_state_t state;
    logic [7:0] div_cnt;
    logic tick;
    logic sclk_q;
    logic cs_n_q;
    logic [39:0] tx_sh;
    logic [23:0] rx_sh;
    logic [5:0] bit_idx;
    logic [5:0] total;
    logic [1:0] nb;
    logic srst_pend;
    logic [3:0] gap_cnt;
    logic [1:0] req_nb;

    // reserved fields forced to defaults, receiver raised with processor
    function automatic logic [7:0] fix_byte(input logic [14:0] a, input logic [7:0] d);
        fix_byte = d;
        if (a == `SCR_OFS_CLKCTL) begin
            fix_byte[`SCR_BIT_CLK_RSV] = 1'b1;
            fix_byte[`SCR_BIT_RECV_EN] = d[`SCR_BIT_RECV_EN] | d[`SCR_BIT_PROC_EN];
        end else if (a == `SCR_OFS_IFACE) begin
            fix_byte = d & `SCR_WMASK_IFACE;
        end else if (a == `SCR_OFS_DEVPWR) begin
            fix_byte = d & `SCR_WMASK_DEVPWR;
        end else if (a == `SCR_OFS_USER) begin
            fix_byte = d & `SCR_WMASK_USER;
        end
    endfunction : fix_byte

    assign req_nb = (nbytes_i == 2'h0) ? 2'h1 : nbytes_i;
    assign total = 6'(`SCR_DATA_FIRST + {nb, 3'b000});
    assign tick = (div_cnt == 8'(SCLK_HALF - 1));
    assign busy_o = (state != SCR_HOST_IDLE);
    assign spi.sclk = sclk_q;
    assign spi.cs_n = cs_n_q;
    assign spi.sdi = tx_sh[39];

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_cnt <= 8'h00;
        end else if (state == SCR_HOST_IDLE || tick) begin
            div_cnt <= 8'h00;
        end else begin
            div_cnt <= 8'(div_cnt + 8'h01);
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= SCR_HOST_IDLE;
            sclk_q <= 1'b0;
            cs_n_q <= 1'b1;
            tx_sh <= 40'h0;
            rx_sh <= 24'h0;
            bit_idx <= 6'h00;
            nb <= 2'h1;
            srst_pend <= 1'b0;
            gap_cnt <= 4'h0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            case (state)
                SCR_HOST_IDLE: begin
                    if (start_i) begin
                        state <= SCR_HOST_SHIFT;
                        cs_n_q <= 1'b0;
                        nb <= req_nb;
                        bit_idx <= 6'h00;
                        tx_sh <= {read_i, addr_i, fix_byte(addr_i, wdata_i[7:0]),
                            fix_byte(15'(addr_i + 15'h0001), wdata_i[15:8]),
                            fix_byte(15'(addr_i + 15'h0002), wdata_i[23:16])};
                        srst_pend <= ~read_i && (addr_i == `SCR_OFS_IFACE)
                            && wdata_i[`SCR_BIT_SOFT_RESET];
                    end
                end
                SCR_HOST_SHIFT: begin
                    if (tick && !sclk_q) begin
                        sclk_q <= 1'b1;
                        bit_idx <= 6'(bit_idx + 6'h01);
                        if (bit_idx >= 6'(`SCR_DATA_FIRST)) begin
                            rx_sh <= {rx_sh[22:0], spi.sdo};
                        end
                    end else if (tick) begin
                        sclk_q <= 1'b0;
                        if (bit_idx == total) begin
                            state <= SCR_HOST_TRAIL;
                        end else begin
                            tx_sh <= {tx_sh[38:0], 1'b0};
                        end
                    end
                end
                SCR_HOST_TRAIL: begin
                    if (tick) begin
                        cs_n_q <= 1'b1;
                        done_o <= 1'b1;
                        gap_cnt <= 4'(`SCR_SRST_HOST_CYC);
                        state <= srst_pend ? SCR_HOST_GAP : SCR_HOST_IDLE;
                    end
                end
                SCR_HOST_GAP: begin
                    // no frames until the soft reset has surely finished
                    if (gap_cnt == 4'h1) begin
                        state <= SCR_HOST_IDLE;
                    end
                    gap_cnt <= 4'(gap_cnt - 4'h1);
                end
                default: begin
                    state <= SCR_HOST_IDLE;
                end
            endcase
        end
    end

    // first byte of the frame lands in the low byte
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= 24'h0;
        end else if (state == SCR_HOST_TRAIL && tick) begin
            if (nb == 2'h1) begin
                rdata_o <= {16'h0, rx_sh[7:0]};
            end else if (nb == 2'h2) begin
                rdata_o <= {8'h0, rx_sh[7:0], rx_sh[15:8]};
            end else begin
                rdata_o <= {rx_sh[7:0], rx_sh[15:8], rx_sh[23:16]};
            end
        end
    end

endmodule : scr_host

// ==== scr_assertions.sv ====
// concurrent checks on the serial link and the device control outputs
`timescale 1ns/10ps
module scr_assertions (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // serial link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdo,
    // device outputs
    input wire logic chip_reset_o,
    input wire scr_pkg::scr_mode_t op_mode_o,
    input wire logic power_down_o,
    input wire logic align_ref_receiver_enable_o,
    input wire logic align_ref_processor_enable_o,
    input wire logic align_ref_fine_step_o,
    input wire logic [3:0] align_ref_delay_select_o
);
    import scr_pkg::*;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // soft reset runs exactly seven cycles (floor of 750 ns at 100 ns)
    sequence srst_run;
        chip_reset_o [*7];
    endsequence
    sequence srst_end;
        srst_run ##1 !chip_reset_o;
    endsequence

    srst_length_a: assert property ($rose(chip_reset_o) |-> srst_end)
        else $error("soft reset pulse has wrong length");
    srst_clears_a: assert property (chip_reset_o && $past(chip_reset_o) |->
        op_mode_o == SCR_MODE_NORMAL && !align_ref_receiver_enable_o && align_ref_delay_select_o == 4'h0)
        else $error("registers not held at reset during soft reset");
    // the host must have closed its frame well before the soft reset ends
    srst_quiet_link_a: assert property (chip_reset_o && $past(chip_reset_o, 5) |-> cs_n && !sclk)
        else $error("serial activity during soft reset");
    sdo_idle_low_a: assert property (cs_n && $past(cs_n) |-> !sdo)
        else $error("sdo driven outside a frame");
    pd_mode_match_a: assert property (power_down_o == (op_mode_o == SCR_MODE_POWER_DOWN))
        else $error("power down does not follow mode field");
    proc_after_recv_a: assert property (align_ref_processor_enable_o |-> align_ref_receiver_enable_o)
        else $error("processor enabled without receiver");
    ctrl_reset_off_a: assert property ($rose(rst_n_i) |->
        !align_ref_receiver_enable_o && !align_ref_processor_enable_o && !align_ref_fine_step_o)
        else $error("align reference controls not off after reset");
    // controls may only move as a frame writes them or a soft reset clears them
    ctrl_in_frame_a: assert property ($changed({align_ref_fine_step_o, align_ref_delay_select_o,
        op_mode_o, align_ref_receiver_enable_o, align_ref_processor_enable_o}) |->
        !$past(cs_n) || chip_reset_o || $past(chip_reset_o))
        else $error("align reference controls changed outside a write");
endmodule : scr_assertions

// ==== tb.sv ====
// self-checking bench: host and device joined over the serial link
`timescale 1ns/10ps
`include "scr_defs.svh"
module tb;
    import scr_pkg::*;
    localparam logic [15:0] MAKER = 16'h1D2B; // arbitrary value
    localparam logic [23:0] EDGE = 24'hC3B2A1;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic start_i = 1'b0;
    logic read_i = 1'b0;
    logic [14:0] addr_i = 15'h0000;
    logic [1:0] nbytes_i = 2'h1;
    logic [23:0] wdata_i = 24'h000000;
    logic [23:0] edge_pos = EDGE;
    logic busy_o, done_o, chip_reset_o, power_down_o, recv_en, proc_en, fine_step;
    logic [23:0] rdata_o;
    logic [3:0] delay_sel;
    scr_mode_t op_mode_o;
    logic [23:0] v;
    int mismatches = 0;
    int checks_done = 0;

    scr_spi_if link();
    scr_device #(.MAKER_CODE(MAKER)) scr_device_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .spi(link),
        .chip_reset_o(chip_reset_o), .op_mode_o(op_mode_o), .power_down_o(power_down_o),
        .align_ref_receiver_enable_o(recv_en), .align_ref_processor_enable_o(proc_en),
        .align_ref_fine_step_o(fine_step), .align_ref_delay_select_o(delay_sel),
        .align_ref_edge_position_i(edge_pos));
    scr_host #(.SCLK_HALF(2)) scr_host_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .spi(link),
        .start_i(start_i), .read_i(read_i), .addr_i(addr_i), .nbytes_i(nbytes_i), .wdata_i(wdata_i),
        .busy_o(busy_o), .done_o(done_o), .rdata_o(rdata_o));
    scr_assertions scr_assertions_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .sclk(link.sclk),
        .cs_n(link.cs_n), .sdo(link.sdo), .chip_reset_o(chip_reset_o), .op_mode_o(op_mode_o),
        .power_down_o(power_down_o), .align_ref_receiver_enable_o(recv_en),
        .align_ref_processor_enable_o(proc_en), .align_ref_fine_step_o(fine_step),
        .align_ref_delay_select_o(delay_sel));

    always #50 ref_clk_i = ~ref_clk_i;

    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk

    // one frame through the host user port; waits out any soft-reset gap first
    task automatic xfer(input logic rd, input logic [14:0] a, input logic [1:0] n, input logic [23:0] wd,
            output logic [23:0] rv);
        int k;
        k = 0;
        @(negedge ref_clk_i);
        while (busy_o !== 1'b0 && k < 400) begin
            @(negedge ref_clk_i);
            k++;
        end
        @(posedge ref_clk_i);
        start_i <= 1'b1;
        read_i <= rd;
        addr_i <= a;
        nbytes_i <= n;
        wdata_i <= wd;
        @(posedge ref_clk_i);
        start_i <= 1'b0;
        k = 0;
        @(negedge ref_clk_i);
        while (done_o !== 1'b1 && k < 400) begin
            @(negedge ref_clk_i);
            k++;
        end
        if (done_o !== 1'b1) begin
            mismatches++;
            $display("wrong value at %0t: frame never completed", $time);
        end
        rv = rdata_o;
    endtask : xfer

    task automatic wr(input logic [14:0] a, input logic [1:0] n, input logic [23:0] d);
        logic [23:0] dummy;
        xfer(1'b0, a, n, d, dummy);
    endtask : wr

    task automatic rd(input logic [14:0] a, input logic [1:0] n, output logic [23:0] rv);
        xfer(1'b1, a, n, 24'h000000, rv);
    endtask : rd

    task automatic t_reset_vals();
        rd(`SCR_OFS_IFACE, 2'd1, v);
        chk(v, 24'h000030);
        rd(`SCR_OFS_DEVPWR, 2'd1, v);
        chk(v, 24'h000000);
        rd(`SCR_OFS_USER, 2'd1, v);
        chk(v, 24'h000000);
        rd(`SCR_OFS_CLKCTL, 2'd1, v);
        chk(v, 24'h000080);
        chk({22'h0, recv_en, proc_en}, 24'h000000);
    endtask : t_reset_vals

    task automatic t_clk_ctrl();
        // processor alone requested: the host must bring the receiver up with it
        wr(`SCR_OFS_CLKCTL, 2'd1, 24'h000040);
        chk({23'h0, recv_en}, 24'h000001);
        chk({23'h0, proc_en}, 24'h000001);
        rd(`SCR_OFS_CLKCTL, 2'd1, v);
        chk(v, 24'h0000E0);
        wr(`SCR_OFS_CLKCTL, 2'd1, 24'h0000B9);
        chk({23'h0, proc_en}, 24'h000000);
        chk({23'h0, recv_en}, 24'h000001);
        chk({23'h0, fine_step}, 24'h000001);
        chk({20'h0, delay_sel}, 24'h000009);
        rd(`SCR_OFS_CLKCTL, 2'd1, v);
        chk(v, 24'h0000B9);
        rd(`SCR_OFS_EDGE_B0, 2'd3, v);
        chk(v, EDGE);
        // a live status input must be read afresh, not a latched copy
        @(posedge ref_clk_i);
        edge_pos <= ~EDGE;
        rd(`SCR_OFS_EDGE_B0, 2'd3, v);
        chk(v, ~EDGE);
        @(posedge ref_clk_i);
        edge_pos <= EDGE;
    endtask : t_clk_ctrl

    task automatic t_modes();
        for (int m = 0; m < 4; m++) begin
            wr(`SCR_OFS_DEVPWR, 2'd1, 24'(m));
            chk({22'h0, op_mode_o}, 24'(m));
            chk({23'h0, power_down_o}, {23'h0, m == 3});
        end
    endtask : t_modes

    task automatic t_maker();
        rd(`SCR_OFS_MAKER_LO, 2'd2, v);
        chk(v, {8'h00, MAKER});
        wr(`SCR_OFS_MAKER_LO, 2'd2, 24'h00FFFF);
        rd(`SCR_OFS_MAKER_LO, 2'd2, v);
        chk(v, {8'h00, MAKER});
    endtask : t_maker

    task automatic t_stream();
        wr(`SCR_OFS_IFACE, 2'd1, 24'h000000);
        rd(`SCR_OFS_IFACE, 2'd1, v);
        chk(v, 24'h000010);
        rd(`SCR_OFS_MAKER_HI, 2'd2, v);
        chk(v, {8'h00, MAKER[7:0], MAKER[15:8]});
        // hold overrides the descending direction set above
        wr(`SCR_OFS_USER, 2'd1, 24'h000001);
        rd(`SCR_OFS_EDGE_B0, 2'd3, v);
        chk(v, {3{EDGE[7:0]}});
    endtask : t_stream

    task automatic t_soft_reset();
        // power down, controls, hold and descend are all set before this point
        wr(`SCR_OFS_IFACE, 2'd1, 24'h000080);
        rd(`SCR_OFS_IFACE, 2'd1, v);
        chk(v, 24'h000030);
        rd(`SCR_OFS_USER, 2'd1, v);
        chk(v, 24'h000000);
        rd(`SCR_OFS_CLKCTL, 2'd2, v);
        chk(v, 24'h000080);
        chk({20'h0, op_mode_o, recv_en, fine_step}, 24'h000000);
    endtask : t_soft_reset

    task automatic end_of_test();
        if (mismatches == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (2) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        t_reset_vals();
        t_clk_ctrl();
        t_modes();
        t_maker();
        t_stream();
        t_soft_reset();
        end_of_test();
    end

    // about 30 frames of under 200 cycles each are expected
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        mismatches++;
        end_of_test();
    end
endmodule : tb
